// ===== rtl/epm_perf_counters.sv
// Per-link E1 performance counters with indirect APB access
//
// Overview of operation
// - Counter overflow sets its own sticky flag
// - Interrupt only from flags with enable set
// - One counter reachable via access port/data
// - Auto-report copies selected counter each second
// - Trigger rising edge copies selected counter
// - After copy, clear selected link's counters
// - Events during clear count in new round
// - 16-bit line code counter, indices 09/08
// - 12-bit framing counter, indices 03/02
// - 10-bit CRC-4 counter, indices 01/00
// - 10-bit far-end block counter, 0D/0C
// - 3-bit alignment change counter, index 04
// - 5-bit out-of-frame counter, index 05
// - 16-bit pattern error counter, 07/06
// - 10-bit national-bit block counter, 0F/0E
// - 10-bit national-bit CRC counter, 0B/0A
// - Control/enable/flag registers per link, link digit
`timescale 1ns/10ps
`include "epm_regs.svh"

module epm_perf_counters #(
	parameter int NUM_LINKS = 8,
	parameter int REPORT_CYCLES = `EPM_REPORT_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [13:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [NUM_LINKS-1:0] lcv_evt_i,
	input wire logic [NUM_LINKS-1:0] fer_evt_i,
	input wire logic [NUM_LINKS-1:0] crc4_evt_i,
	input wire logic [NUM_LINKS-1:0] far_end_block_error_count_evt_i,
	input wire logic [NUM_LINKS-1:0] alignment_change_count_evt_i,
	input wire logic [NUM_LINKS-1:0] oof_evt_i,
	input wire logic [NUM_LINKS-1:0] pattern_error_count_evt_i,
	input wire logic [NUM_LINKS-1:0] nt_far_end_block_error_count_evt_i,
	input wire logic [NUM_LINKS-1:0] nt_crc_evt_i,
	output logic irq_o
);

	localparam int NC = epm_pkg::EPM_C_NUM;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	epm_pkg::epm_cnt_t cnt_ff [NUM_LINKS][NC];
	epm_pkg::epm_vec_t flag_ff [NUM_LINKS];
	epm_pkg::epm_vec_t evt [NUM_LINKS];
	logic [7:0] ctrl_ff [NUM_LINKS];
	logic [7:0] en0_ff [NUM_LINKS];
	logic [7:0] en1_ff [NUM_LINKS];
	logic [NUM_LINKS-1:0] trig_prev_ff;
	logic [3:0] sel_idx_ff;
	logic [2:0] sel_link_ff;
	logic [7:0] data_ff;
	logic [31:0] tb_cnt_ff;
	logic tick_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic irq_ff;
	logic [11:0] idx;
	logic [2:0] acc_link;
	logic [7:0] acc_lo;
	logic is_link_reg;
	logic rd_hit;
	logic [31:0] rd_val;
	logic wr_en;
	logic manual_rise;
	logic snap;
	logic [7:0] sel_byte;
	logic apb_setup;
	logic tick_due;
	logic [NUM_LINKS-1:0] snap_link;
	logic [NUM_LINKS-1:0] irq_link;
	epm_pkg::epm_vec_t ovf_vec [NUM_LINKS];
	epm_pkg::epm_vec_t clr_vec [NUM_LINKS];
	epm_pkg::epm_cnt_t nxt_cnt [NUM_LINKS][NC];

	// Largest value a counter slot can hold
	function automatic epm_pkg::epm_cnt_t cnt_max(input int k);
		int w;
		w = 16;
		case (k)
			epm_pkg::EPM_C_CRC: w = `EPM_W_CRC;
			epm_pkg::EPM_C_FER: w = `EPM_W_FER;
			epm_pkg::EPM_C_LCV: w = `EPM_W_LCV;
			epm_pkg::EPM_C_FAR_END_BLOCK_ERROR_COUNT: w = `EPM_W_FAR_END_BLOCK_ERROR_COUNT;
			epm_pkg::EPM_C_ALIGNMENT_CHANGE_COUNT: w = `EPM_W_ALIGNMENT_CHANGE_COUNT;
			epm_pkg::EPM_C_OOF: w = `EPM_W_OOF;
			epm_pkg::EPM_C_PATTERN_ERROR_COUNT: w = `EPM_W_PATTERN_ERROR_COUNT;
			epm_pkg::EPM_C_NT_REMOTE_BLOCK_ERROR_COUNT: w = `EPM_W_NT_REMOTE_BLOCK_ERROR_COUNT;
			epm_pkg::EPM_C_TCRC: w = `EPM_W_TCRC;
			default: w = 16;
		endcase
		cnt_max = 16'((32'h1 << w) - 32'h1);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Event gathering, in flag bit order

	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			evt[l] = {nt_crc_evt_i[l], nt_far_end_block_error_count_evt_i[l], pattern_error_count_evt_i[l], oof_evt_i[l], alignment_change_count_evt_i[l],
				far_end_block_error_count_evt_i[l], lcv_evt_i[l], fer_evt_i[l], crc4_evt_i[l]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode

	// Word index and per-link split of the address
	assign idx = paddr_i[13:2];
	assign acc_link = idx[10:8];
	assign acc_lo = idx[7:0];
	assign is_link_reg = (idx[11] == 1'b0) && (32'(acc_link) < NUM_LINKS);
	assign wr_en = psel_i && penable_i && pready_ff && pwrite_i;
	assign apb_setup = psel_i && !penable_i;

	// Read mux; unmapped addresses read zero with an error
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0;
		if (idx == `EPM_IDX_ACCESS_PORT) begin
			rd_val = {24'h0, 1'b0, sel_link_ff, sel_idx_ff};
		end else if (idx == `EPM_IDX_ACCESS_DATA) begin
			rd_val = {24'h0, data_ff};
		end else if (is_link_reg && acc_lo == `EPM_LO_SNAP_CTRL) begin
			rd_val = {24'h0, ctrl_ff[acc_link]};
		end else if (is_link_reg && acc_lo == `EPM_LO_OVF_EN0) begin
			rd_val = {24'h0, en0_ff[acc_link]};
		end else if (is_link_reg && acc_lo == `EPM_LO_OVF_EN1) begin
			rd_val = {24'h0, en1_ff[acc_link]};
		end else if (is_link_reg && acc_lo == `EPM_LO_OVF_FLG0) begin
			rd_val = {26'h0, flag_ff[acc_link][8:3]};
		end else if (is_link_reg && acc_lo == `EPM_LO_OVF_FLG1) begin
			rd_val = {29'h0, flag_ff[acc_link][2:0]};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Ready one cycle after setup, so every transfer has one access cycle
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= apb_setup;
			pslverr_ff <= apb_setup && !rd_hit;
			if (apb_setup) begin
				prdata_ff <= rd_hit ? rd_val : 32'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers

	// Access port: link and counter index selection
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_idx_ff <= 4'(`EPM_RST_PORT);
			sel_link_ff <= 3'h0;
		end else if (wr_en && idx == `EPM_IDX_ACCESS_PORT) begin
			sel_idx_ff <= pwdata_i[`EPM_PORT_IDX_LSB +: 4];
			sel_link_ff <= pwdata_i[`EPM_PORT_LINK_LSB +: 3];
		end
	end

	// Per-link control and overflow enable registers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				ctrl_ff[l] <= `EPM_RST_CTRL;
				en0_ff[l] <= `EPM_RST_EN;
				en1_ff[l] <= `EPM_RST_EN;
			end
		end else if (wr_en && is_link_reg) begin
			if (acc_lo == `EPM_LO_SNAP_CTRL) begin
				ctrl_ff[acc_link] <= {6'h0, pwdata_i[1:0]};
			end
			if (acc_lo == `EPM_LO_OVF_EN0) begin
				en0_ff[acc_link] <= {2'h0, pwdata_i[5:0]};
			end
			if (acc_lo == `EPM_LO_OVF_EN1) begin
				en1_ff[acc_link] <= {5'h0, pwdata_i[2:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Snapshot timing

	// Last cycle of a report interval
	assign tick_due = (tb_cnt_ff == 32'(REPORT_CYCLES - 1));

	// Free-running one-second timebase, shared by all links
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tb_cnt_ff <= 32'h0;
			tick_ff <= 1'b0;
		end else if (tick_due) begin
			tb_cnt_ff <= 32'h0;
			tick_ff <= 1'b1;
		end else begin
			tb_cnt_ff <= tb_cnt_ff + 32'h1;
			tick_ff <= 1'b0;
		end
	end

	// Previous trigger level of every link for edge detection
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trig_prev_ff <= '0;
		end else begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				trig_prev_ff[l] <= ctrl_ff[l][`EPM_CTRL_MANUAL_BIT];
			end
		end
	end

	// Manual edge on the selected link, or the second tick while auto is on
	assign manual_rise = ctrl_ff[sel_link_ff][`EPM_CTRL_MANUAL_BIT] && !trig_prev_ff[sel_link_ff];
	assign snap = manual_rise || (tick_ff && ctrl_ff[sel_link_ff][`EPM_CTRL_AUTO_BIT]);

	////////////////////////////////////////////////////////////////////////
	// Indirect byte selection

	// Map counter index to counter slot and byte
	always_comb begin
		sel_byte = 8'h0;
		unique case (sel_idx_ff)
			4'h0: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_CRC][7:0];
			4'h1: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_CRC][15:8];
			4'h2: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_FER][7:0];
			4'h3: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_FER][15:8];
			4'h4: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_ALIGNMENT_CHANGE_COUNT][7:0];
			4'h5: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_OOF][7:0];
			4'h6: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_PATTERN_ERROR_COUNT][7:0];
			4'h7: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_PATTERN_ERROR_COUNT][15:8];
			4'h8: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_LCV][7:0];
			4'h9: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_LCV][15:8];
			4'ha: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_TCRC][7:0];
			4'hb: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_TCRC][15:8];
			4'hc: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_FAR_END_BLOCK_ERROR_COUNT][7:0];
			4'hd: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_FAR_END_BLOCK_ERROR_COUNT][15:8];
			4'he: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_NT_REMOTE_BLOCK_ERROR_COUNT][7:0];
			4'hf: sel_byte = cnt_ff[sel_link_ff][epm_pkg::EPM_C_NT_REMOTE_BLOCK_ERROR_COUNT][15:8];
		endcase
	end

	// Data register holds until the next snapshot
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_ff <= `EPM_RST_DATA;
		end else if (snap) begin
			data_ff <= sel_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counters and overflow flags

	// Link whose counters restart at this edge
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			snap_link[l] = snap && (32'(sel_link_ff) == l);
		end
	end

	// An event at the top of a slot wraps it, unless the link restarts anyway
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			for (int k = 0; k < NC; k++) begin
				ovf_vec[l][k] = evt[l][k] && (cnt_ff[l][k] == cnt_max(k)) && !snap_link[l];
			end
		end
	end

	// Next count; an event in the clear cycle starts the new round at one
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			for (int k = 0; k < NC; k++) begin
				nxt_cnt[l][k] = cnt_ff[l][k];
				if (snap_link[l]) begin
					nxt_cnt[l][k] = {15'h0, evt[l][k]};
				end else if (ovf_vec[l][k]) begin
					nxt_cnt[l][k] = 16'h0;
				end else if (evt[l][k]) begin
					nxt_cnt[l][k] = 16'(cnt_ff[l][k] + 16'h1);
				end
			end
		end
	end

	// Counter registers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				for (int k = 0; k < NC; k++) begin
					cnt_ff[l][k] <= 16'h0;
				end
			end
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Write-one-to-clear requests mapped onto flag slots
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			clr_vec[l] = '0;
			if (wr_en && is_link_reg && (32'(acc_link) == l)) begin
				if (acc_lo == `EPM_LO_OVF_FLG1) begin
					clr_vec[l][`EPM_FLG1_CNT-1:0] = pwdata_i[`EPM_FLG1_CNT-1:0];
				end
				if (acc_lo == `EPM_LO_OVF_FLG0) begin
					clr_vec[l][NC-1:`EPM_FLG1_CNT] = pwdata_i[NC-`EPM_FLG1_CNT-1:0];
				end
			end
		end
	end

	// Sticky overflow flags; a new overflow wins over a same-cycle clear
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				flag_ff[l] <= '0;
			end
		end else begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				flag_ff[l] <= ovf_vec[l] | (flag_ff[l] & ~clr_vec[l]);
			end
		end
	end

	// Enabled overflow flags of each link
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) begin
			irq_link[l] = |(flag_ff[l] & {en0_ff[l][5:0], en1_ff[l][2:0]});
		end
	end

	// Interrupt from enabled flags of any link
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |irq_link;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata_o = prdata_ff;
	assign pready_o = pready_ff;
	assign pslverr_o = pslverr_ff;
	assign irq_o = irq_ff;

endmodule

// ===== rtl/epm_pkg.sv
// Types shared by the performance counter block
package epm_pkg;
	// Counter slots, in flag bit order
	typedef enum {
		EPM_C_CRC,
		EPM_C_FER,
		EPM_C_LCV,
		EPM_C_FAR_END_BLOCK_ERROR_COUNT,
		EPM_C_ALIGNMENT_CHANGE_COUNT,
		EPM_C_OOF,
		EPM_C_PATTERN_ERROR_COUNT,
		EPM_C_NT_REMOTE_BLOCK_ERROR_COUNT,
		EPM_C_TCRC,
		EPM_C_NUM
	} epm_ctr_t;
	typedef logic [15:0] epm_cnt_t;
	typedef logic [8:0] epm_vec_t;
endpackage

// ===== rtl/epm_regs.svh
// Register indices, field positions, reset values and timing for the performance counters
`ifndef EPM_REGS_SVH
`define EPM_REGS_SVH

// Register indices; byte address is four times the index
`define EPM_IDX_ACCESS_PORT 12'h00e
`define EPM_IDX_ACCESS_DATA 12'h00f
// Per-link registers: link number forms index bits [10:8]
`define EPM_LO_SNAP_CTRL 8'hc2
`define EPM_LO_OVF_EN0 8'hc3
`define EPM_LO_OVF_EN1 8'hc4
`define EPM_LO_OVF_FLG0 8'hc5
`define EPM_LO_OVF_FLG1 8'hc6

// Field positions
`define EPM_CTRL_MANUAL_BIT 0
`define EPM_CTRL_AUTO_BIT 1
`define EPM_PORT_IDX_LSB 0
`define EPM_PORT_LINK_LSB 4
// Flags/enables: register 1 holds counters 2..0, register 0 holds counters 8..3
`define EPM_FLG1_CNT 3

// Reset values
`define EPM_RST_CTRL 8'h00
`define EPM_RST_EN 8'h00
`define EPM_RST_PORT 8'h00
`define EPM_RST_DATA 8'h00

// Counter widths
`define EPM_W_CRC 10
`define EPM_W_FER 12
`define EPM_W_LCV 16
`define EPM_W_FAR_END_BLOCK_ERROR_COUNT 10
`define EPM_W_ALIGNMENT_CHANGE_COUNT 3
`define EPM_W_OOF 5
`define EPM_W_PATTERN_ERROR_COUNT 16
`define EPM_W_NT_REMOTE_BLOCK_ERROR_COUNT 10
`define EPM_W_TCRC 10

// Report interval
`define EPM_REPORT_PERIOD_MS 1000
`define EPM_CLK_KHZ 200000
`define EPM_REPORT_CYCLES (`EPM_REPORT_PERIOD_MS * `EPM_CLK_KHZ)

`endif

// ===== sim/epm_host.sv
// Host processor model: APB master for register access
`timescale 1ns/10ps
module epm_host (
	input wire logic clk_i,
	output logic psel_o = 1'b0,
	output logic penable_o = 1'b0,
	output logic pwrite_o = 1'b0,
	output logic [13:0] paddr_o = 14'h0,
	output logic [31:0] pwdata_o = 32'h0,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	// One transfer; counters only reached through port and data words
	task xfer(input logic w, input logic [11:0] idx, input logic [7:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= {idx, 2'b00};
		pwdata_o <= {24'h0, wd};
		@(posedge clk_i);
		penable_o <= 1'b1;
		do @(posedge clk_i); while (pready_i !== 1'b1);
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule

// ===== sim/epm_perf_counters_props.sv
// Port-level checks for the performance counter block
`timescale 1ns/10ps
module epm_perf_counters_props (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Setup phase and its single-cycle answer
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_answer;
		pready_o ##1 !pready_o;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> s_answer) else $error("no single ready after setup");
	a_ready_in_access: assert property (pready_o |-> psel_i && penable_i) else $error("ready outside access");
	a_idle_no_ready: assert property (!psel_i |=> !pready_o) else $error("ready while idle");
	a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
	a_err_one_cycle: assert property (pslverr_o |=> !pslverr_o) else $error("error held too long");
	a_err_reads_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0) else $error("bad error data");
	a_rdata_byte_only: assert property (pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper data set");
	a_data_holds: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o)) else $error("data moved");
endmodule
bind epm_perf_counters epm_perf_counters_props u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o));

// ===== sim/epm_perf_counters_tb.sv
// Self-checking bench for the performance counter block
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value %s exp %0h got %0h", n, e, g); end end
module epm_perf_counters_tb;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq, er;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] d;
	logic [7:0] ev [9];
	logic [3:0] lo [9] = '{4'h0, 4'h2, 4'h8, 4'hc, 4'h4, 4'h5, 4'h6, 4'he, 4'ha};
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	always #2.5 core_clk_i = ~core_clk_i;
	initial foreach (ev[k]) ev[k] = 8'h00;
	epm_host host (.clk_i(core_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
	epm_perf_counters #(.REPORT_CYCLES(50)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .crc4_evt_i(ev[0]), .fer_evt_i(ev[1]),
		.lcv_evt_i(ev[2]), .far_end_block_error_count_evt_i(ev[3]), .alignment_change_count_evt_i(ev[4]), .oof_evt_i(ev[5]), .pattern_error_count_evt_i(ev[6]),
		.nt_far_end_block_error_count_evt_i(ev[7]), .nt_crc_evt_i(ev[8]), .irq_o(irq));
	////////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task summarize();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	// Hold one event line high for n cycles
	task pulse(input int k, input int l, input int n);
		@(posedge core_clk_i);
		ev[k][l] <= 1'b1;
		repeat (n) @(posedge core_clk_i);
		ev[k][l] <= 1'b0;
	endtask
	// Select link and index, raise the trigger, fetch the byte
	task snap(input logic [2:0] l, input logic [3:0] i);
		host.xfer(1'b1, 12'h00e, {1'b0, l, i}, rd, er);
		host.xfer(1'b1, {1'b0, l, 8'hc2}, 8'h00, rd, er);
		host.xfer(1'b1, {1'b0, l, 8'hc2}, 8'h01, rd, er);
		repeat (3) @(posedge core_clk_i);
		host.xfer(1'b0, 12'h00f, 8'h00, rd, er);
		d = rd[7:0];
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_map();
		for (int k = 0; k < 9; k++) begin
			pulse(k, 4, 3 + k);
			snap(3'h4, lo[k]);
			`CHK("low byte", 8'(3 + k), d)
		end
		snap(3'h4, 4'h4);
		`CHK("cleared", 8'h00, d)
	endtask
	task t_split();
		pulse(2, 2, 291);
		snap(3'h2, 4'h8);
		`CHK("lcv lo", 8'h23, d)
		pulse(2, 2, 291);
		snap(3'h2, 4'h9);
		`CHK("lcv hi", 8'h01, d)
	endtask
	task t_ovf();
		pulse(4, 1, 8);
		host.xfer(1'b0, 12'h1c5, 8'h00, rd, er);
		`CHK("flags", 32'h02, rd)
		`CHK("irq masked", 1'b0, irq)
		host.xfer(1'b1, 12'h1c3, 8'h02, rd, er);
		repeat (2) @(posedge core_clk_i);
		#1;
		`CHK("irq on", 1'b1, irq)
		host.xfer(1'b1, 12'h1c5, 8'h02, rd, er);
		repeat (3) @(posedge core_clk_i);
		#1;
		`CHK("irq off", 1'b0, irq)
	endtask
	task t_auto();
		host.xfer(1'b1, 12'h00e, 8'h05, rd, er);
		host.xfer(1'b1, 12'h0c2, 8'h02, rd, er);
		ev[5][0] <= 1'b1;
		repeat (120) @(posedge core_clk_i);
		host.xfer(1'b0, 12'h00f, 8'h00, rd, er);
		`CHK("auto", 32'h12, rd)
		host.xfer(1'b1, 12'h0c2, 8'h00, rd, er);
		ev[5][0] <= 1'b0;
		repeat (60) @(posedge core_clk_i);
		host.xfer(1'b1, 12'h00f, 8'hff, rd, er);
		`CHK("ro err", 1'b0, er)
		host.xfer(1'b0, 12'h00f, 8'h00, rd, er);
		`CHK("held", 32'h12, rd)
	endtask
	task t_regs();
		host.xfer(1'b1, 12'h7c2, 8'h02, rd, er);
		host.xfer(1'b0, 12'h7c2, 8'h00, rd, er);
		`CHK("link7", 32'h02, rd)
		host.xfer(1'b0, 12'h6c2, 8'h00, rd, er);
		`CHK("link6", 32'h00, rd)
		host.xfer(1'b1, 12'h7c2, 8'h00, rd, er);
		host.xfer(1'b0, 12'h0c7, 8'h00, rd, er);
		`CHK("unmapped", 1'b1, er)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		host.xfer(1'b0, 12'h3c4, 8'h00, rd, er);
		`CHK("reset", 32'h00, rd)
		t_map();
		t_split();
		t_ovf();
		t_auto();
		t_regs();
		summarize();
	end
endmodule
